//--- pcr_pkg.sv
// Constants, encodings and carrier types of the position compare-reset unit.
// Assumes a single core_clk domain shared with the axis counters and the user program.
//
// Function
// - When the selected position becomes equal to the target, the configured result bit is cleared.
// - Selector codes 0, 1 and 2 pick the X, Y and Z pulse-output positions; codes outside 0 to 2 and 11 to 13 are refused.
// - Selector codes 11, 12 and 13 pick the X, Y and Z electronic-cam master positions.
// - Target and every source are compared over the full 32 bits, and callers use only that form.
// - A result bit on a fast output point is driven to the pin in the cycle after the match.
// - A result bit on a slow output point reaches its pin only when the current scan ends.
// - A result bit on an internal relay is updated in the cycle after the match.
// - All operations active on one axis use one source, and a mismatch is flagged.
package pcr_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int SLOTS     = 4;
    localparam int SLOT_W    = 2;
    localparam int POS_W     = 32;
    localparam int SEL_W     = 8;
    localparam int AXES      = 3;
    localparam int FAST_PTS  = 16;
    localparam int SLOW_PTS  = 16;
    localparam int RELAYS    = 64;
    localparam int IDX_W     = 6;
    localparam int PT_IDX_W  = 4;

    // ------------------------------------------------------------------
    // Source selector codes
    // ------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_X_PULSE = 8'h00;
    localparam logic [SEL_W-1:0] SEL_Y_PULSE = 8'h01;
    localparam logic [SEL_W-1:0] SEL_Z_PULSE = 8'h02;
    localparam logic [SEL_W-1:0] SEL_X_CAM   = 8'h0B;
    localparam logic [SEL_W-1:0] SEL_Y_CAM   = 8'h0C;
    localparam logic [SEL_W-1:0] SEL_Z_CAM   = 8'h0D;
    localparam logic [1:0]       AXIS_NONE   = 2'h3;

    // ------------------------------------------------------------------
    // Result destination kinds
    // ------------------------------------------------------------------
    localparam logic [1:0] DEST_FAST  = 2'h0;
    localparam logic [1:0] DEST_SLOW  = 2'h1;
    localparam logic [1:0] DEST_RELAY = 2'h2;

    typedef struct packed {
        logic [1:0]       kind;
        logic [IDX_W-1:0] index;
    } pcr_dest_t;

    typedef struct packed {
        logic [SLOT_W-1:0] slot;
        logic              arm;
        logic [POS_W-1:0]  target;
        logic [SEL_W-1:0]  sel;
        pcr_dest_t         dest;
    } pcr_cfg_t;

    typedef struct packed {
        pcr_dest_t dest;
        logic      value;
    } pcr_bitwr_t;

    typedef struct packed {
        logic [SLOTS-1:0]            armed;
        logic [SLOTS-1:0][POS_W-1:0] target;
        logic [SLOTS-1:0][SEL_W-1:0] sel;
        logic [SLOTS-1:0][7:0]       dest;
        logic [SLOTS-1:0]            matchPrev;
        logic [SLOTS-1:0]            hit;
        logic [FAST_PTS-1:0]         fastOut;
        logic [SLOW_PTS-1:0]         slowImage;
        logic [SLOW_PTS-1:0]         slowOut;
        logic [RELAYS-1:0]           relay;
        logic                        selError;
        logic [AXES-1:0]             conflict;
    } pcr_state_t;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam pcr_state_t STATE_RST = '0;

endpackage

//--- pcr_compare_reset.sv
// Position compare-reset unit: clears a result bit when a selected axis position hits a target.
// Assumes positions, configuration, bit writes and the scan-end strobe all come on core_clk.
`timescale 1ns/100ps

module pcr_compare_reset
(
    // Clock, reset and enable
    input  wire logic                                        core_clk,
    input  wire logic                                        rst,
    input  wire logic                                        clkEn,
    // Axis positions
    input  wire logic [pcr_pkg::AXES-1:0][pcr_pkg::POS_W-1:0] pulsePos,
    input  wire logic [pcr_pkg::AXES-1:0][pcr_pkg::POS_W-1:0] camPos,
    // User program requests
    input  wire logic                                        cfgValid,
    input  wire pcr_pkg::pcr_cfg_t                           cfgReq,
    input  wire logic                                        bitWrValid,
    input  wire pcr_pkg::pcr_bitwr_t                         bitWr,
    input  wire logic                                        scanDone,
    // Result bits
    output logic      [pcr_pkg::FAST_PTS-1:0]                fastOut,
    output logic      [pcr_pkg::SLOW_PTS-1:0]                slowOut,
    output logic      [pcr_pkg::RELAYS-1:0]                  relayBits,
    // Status
    output logic      [pcr_pkg::SLOTS-1:0]                   matchPulse,
    output logic                                             selError,
    output logic      [pcr_pkg::AXES-1:0]                    sourceConflict
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    function automatic logic [1:0] selAxis(input logic [pcr_pkg::SEL_W-1:0] sel);
        logic [1:0] axis;
        axis = pcr_pkg::AXIS_NONE;
        if (sel == pcr_pkg::SEL_X_PULSE || sel == pcr_pkg::SEL_X_CAM)
            axis = 2'h0;
        else if (sel == pcr_pkg::SEL_Y_PULSE || sel == pcr_pkg::SEL_Y_CAM)
            axis = 2'h1;
        else if (sel == pcr_pkg::SEL_Z_PULSE || sel == pcr_pkg::SEL_Z_CAM)
            axis = 2'h2;
        return axis;
    endfunction

    function automatic logic selIsCam(input logic [pcr_pkg::SEL_W-1:0] sel);
        return sel >= pcr_pkg::SEL_X_CAM;
    endfunction

    // Hardware clears are applied after user writes, so a match never loses to a write.
    function automatic pcr_pkg::pcr_state_t writeBit(input pcr_pkg::pcr_state_t s,
                                                    input pcr_pkg::pcr_dest_t  d,
                                                    input logic                v);
        pcr_pkg::pcr_state_t r;
        r = s;
        case (d.kind)
            pcr_pkg::DEST_FAST:  r.fastOut[d.index[pcr_pkg::PT_IDX_W-1:0]] = v;
            pcr_pkg::DEST_SLOW:  r.slowImage[d.index[pcr_pkg::PT_IDX_W-1:0]] = v;
            pcr_pkg::DEST_RELAY: r.relay[d.index] = v;
            default:             r = s;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pcr_pkg::pcr_state_t                                st;
    pcr_pkg::pcr_state_t                                next_st;
    logic [pcr_pkg::SLOTS-1:0][pcr_pkg::POS_W-1:0]      selPos;
    logic [pcr_pkg::SLOTS-1:0]                          eq;
    logic [pcr_pkg::SLOTS-1:0]                          eqRise;

    // ------------------------------------------------------------------
    // Source selection and comparison
    // ------------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < pcr_pkg::SLOTS; g++)
        begin : gSlot
            logic [1:0] ax;
            assign ax = selAxis(st.sel[g]);
            // Unsupported codes never arm, so the fallback axis is harmless.
            assign selPos[g] = (ax == pcr_pkg::AXIS_NONE) ? '0 :
                               selIsCam(st.sel[g]) ? camPos[ax] : pulsePos[ax];
            // Full-width equality, tried on every clock while armed.
            assign eq[g]     = st.armed[g] && (selPos[g] == st.target[g]);
            assign eqRise[g] = eq[g] && !st.matchPrev[g];
        end
    endgenerate

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st          = st;
        next_st.hit      = '0;
        next_st.selError = 1'b0;
        if (bitWrValid)
            next_st = writeBit(next_st, bitWr.dest, bitWr.value);
        for (int s = 0; s < pcr_pkg::SLOTS; s++)
        begin
            next_st.matchPrev[s] = eq[s];
            if (eqRise[s])
            begin
                next_st.hit[s] = 1'b1;
                // Fast points and relays change at once; slow points wait in the image.
                next_st = writeBit(next_st, st.dest[s], 1'b0);
            end
        end
        if (cfgValid)
        begin
            if (cfgReq.arm && selAxis(cfgReq.sel) == pcr_pkg::AXIS_NONE)
            begin
                next_st.selError            = 1'b1;
                next_st.armed[cfgReq.slot]  = 1'b0;
            end
            else
            begin
                next_st.armed[cfgReq.slot]     = cfgReq.arm;
                next_st.target[cfgReq.slot]    = cfgReq.target;
                next_st.sel[cfgReq.slot]       = cfgReq.sel;
                next_st.dest[cfgReq.slot]      = cfgReq.dest;
                next_st.matchPrev[cfgReq.slot] = 1'b0;
            end
        end
        for (int a = 0; a < pcr_pkg::AXES; a++)
        begin
            next_st.conflict[a] = 1'b0;
            for (int i = 0; i < pcr_pkg::SLOTS; i++)
            begin
                for (int j = i + 1; j < pcr_pkg::SLOTS; j++)
                begin
                    if (st.armed[i] && st.armed[j] && selAxis(st.sel[i]) == 2'(a)
                        && selAxis(st.sel[j]) == 2'(a) && st.sel[i] != st.sel[j])
                        next_st.conflict[a] = 1'b1;
                end
            end
        end
        if (scanDone)
            next_st.slowOut = next_st.slowImage;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            st <= pcr_pkg::STATE_RST;
        else if (clkEn)
            st <= next_st;
    end

    assign fastOut        = st.fastOut;
    assign slowOut        = st.slowOut;
    assign relayBits      = st.relay;
    assign matchPulse     = st.hit;
    assign selError       = st.selError;
    assign sourceConflict = st.conflict;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    pcr_pkg::pcr_dest_t d0;
    assign d0 = st.dest[0];

    property p_hit_on_match;
        clkEn && eqRise[0] |=> matchPulse[0] && !$past(st.matchPrev[0]);
    endproperty
    a_hit_on_match: assert property (p_hit_on_match) else $error("match not reported");

    property p_pulse_source;
        st.sel[0] == pcr_pkg::SEL_X_PULSE |-> selPos[0] == pulsePos[0];
    endproperty
    a_pulse_source: assert property (p_pulse_source) else $error("wrong pulse source");

    property p_cam_source;
        st.sel[0] == pcr_pkg::SEL_Z_CAM |-> selPos[0] == camPos[2];
    endproperty
    a_cam_source: assert property (p_cam_source) else $error("wrong cam source");

    property p_refuse_code;
        clkEn && cfgValid && cfgReq.arm && selAxis(cfgReq.sel) == pcr_pkg::AXIS_NONE
            |=> selError && !st.armed[$past(cfgReq.slot)];
    endproperty
    a_refuse_code: assert property (p_refuse_code) else $error("bad code accepted");

    property p_full_width;
        selPos[0][31:16] != st.target[0][31:16] |-> !eqRise[0];
    endproperty
    a_full_width: assert property (p_full_width) else $error("partial compare");

    property p_fast_clear;
        clkEn && eqRise[0] && d0.kind == pcr_pkg::DEST_FAST
            |=> fastOut[$past(d0.index[3:0])] == 1'b0;
    endproperty
    a_fast_clear: assert property (p_fast_clear) else $error("fast point not cleared");

    property p_slow_hold;
        !(clkEn && scanDone) |=> $stable(slowOut);
    endproperty
    a_slow_hold: assert property (p_slow_hold) else $error("slow point moved mid scan");

    property p_relay_clear;
        clkEn && eqRise[0] && d0.kind == pcr_pkg::DEST_RELAY
            |=> relayBits[$past(d0.index)] == 1'b0;
    endproperty
    a_relay_clear: assert property (p_relay_clear) else $error("relay not cleared");

    property p_conflict;
        clkEn && st.armed[0] && st.armed[1] && selAxis(st.sel[0]) == 2'h0
            && selAxis(st.sel[1]) == 2'h0 && st.sel[0] != st.sel[1] |=> sourceConflict[0];
    endproperty
    a_conflict: assert property (p_conflict) else $error("source mismatch not flagged");

    property p_slow_update;
        clkEn && scanDone |=> slowOut == st.slowImage;
    endproperty
    a_slow_update: assert property (p_slow_update) else $error("slow point missed scan end");

    property p_error_pulse;
        clkEn && !cfgValid |=> !selError;
    endproperty
    a_error_pulse: assert property (p_error_pulse) else $error("spurious code error");

endmodule // pcr_compare_reset

//--- pcr_axis_model.sv
// Partner model: the axis position counters that feed the compare unit.
// Assumes the bench loads a base value, then lets every axis step once per clock.
`timescale 1ns/100ps

module pcr_axis_model
(
    // Clock and reset
    input  wire logic                                         core_clk,
    input  wire logic                                         rst,
    // Bench control
    input  wire logic                                         load,
    input  wire logic                                         run,
    input  wire logic [31:0]                                  base,
    // Positions
    output logic      [pcr_pkg::AXES-1:0][pcr_pkg::POS_W-1:0] pulsePos,
    output logic      [pcr_pkg::AXES-1:0][pcr_pkg::POS_W-1:0] camPos
);
    // Steps of one make each target be crossed, never jumped, between scans.
    // No counter source is modelled, so only the pulse and cam sources run per axis.
    always_ff @(posedge core_clk or posedge rst)
    begin
        for (int a = 0; a < pcr_pkg::AXES; a++)
        begin
            if (rst)
            begin
                pulsePos[a] <= 32'h0;
                camPos[a]   <= 32'h0;
            end
            else if (load)
            begin
                pulsePos[a] <= base + 32'(a) * 32'h100;
                camPos[a]   <= base + 32'(a) * 32'h100 + 32'h10000;
            end
            else if (run)
            begin
                pulsePos[a] <= pulsePos[a] + 32'h1;
                camPos[a]   <= camPos[a] + 32'h1;
            end
        end
    end
endmodule // pcr_axis_model

//--- position_compare_reset_tb.sv
// Self-checking bench of the position compare-reset unit.
// Assumes the axis model drives the positions; the bench plays the user program.
`timescale 1ns/100ps

module position_compare_reset_tb;
    logic core_clk = 1'b0, rst = 1'b1, clkEn = 1'b1, load = 1'b0, run = 1'b0;
    logic cfgValid = 1'b0, bitWrValid = 1'b0, scanDone = 1'b0;
    logic [31:0] base = 32'h0, seed = 32'h96EC, p;
    logic [7:0] sel;
    logic [2:0][31:0] pulsePos, camPos;
    pcr_pkg::pcr_cfg_t cfgReq = '0;
    pcr_pkg::pcr_bitwr_t bitWr = '0;
    pcr_pkg::pcr_dest_t d = '0;
    logic [15:0] fastOut, slowOut;
    logic [63:0] relayBits;
    logic [3:0] matchPulse;
    logic selError;
    logic [2:0] sourceConflict;
    int num_errors = 0, comparisons = 0, n;
    logic [7:0] codes [6] = '{pcr_pkg::SEL_X_PULSE, pcr_pkg::SEL_Y_PULSE, pcr_pkg::SEL_Z_PULSE,
                              pcr_pkg::SEL_X_CAM, pcr_pkg::SEL_Y_CAM, pcr_pkg::SEL_Z_CAM};

    always #20 core_clk = ~core_clk;

    pcr_axis_model model (.core_clk(core_clk), .rst(rst), .load(load), .run(run),
                          .base(base), .pulsePos(pulsePos), .camPos(camPos));
    pcr_compare_reset dut (.core_clk(core_clk), .rst(rst), .clkEn(clkEn),
        .pulsePos(pulsePos), .camPos(camPos), .cfgValid(cfgValid), .cfgReq(cfgReq),
        .bitWrValid(bitWrValid), .bitWr(bitWr), .scanDone(scanDone), .fastOut(fastOut),
        .slowOut(slowOut), .relayBits(relayBits), .matchPulse(matchPulse),
        .selError(selError), .sourceConflict(sourceConflict));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] exp_pos(input logic [7:0] sl, input logic [31:0] b);
        logic cam;
        cam = (sl >= pcr_pkg::SEL_X_CAM);
        return b + 32'(cam ? sl - pcr_pkg::SEL_X_CAM : sl) * 32'h100 + (cam ? 32'h10000 : 32'h0);
    endfunction

    function automatic logic bit_now();
        case (d.kind)
            pcr_pkg::DEST_FAST: return fastOut[d.index[3:0]];
            pcr_pkg::DEST_SLOW: return slowOut[d.index[3:0]];
            default:            return relayBits[d.index];
        endcase
    endfunction

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Raises a strobe for exactly one taking edge.
    task automatic strobe(ref logic s);
        @(posedge core_clk);
        #1 s = 1'b1;
        @(posedge core_clk);
        #1 s = 1'b0;
    endtask

    task automatic arm_slot(input logic [1:0] s, input logic a, input logic [31:0] t);
        cfgReq = '{s, a, t, sel, d};
        strobe(cfgValid);
    endtask

    task automatic complete_run();
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #2000000;
        num_errors++;
        complete_run();
    end

    initial
    begin
        repeat (2) @(posedge core_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            // Every source code, each destination kind twice.
            sel = codes[i];
            p = rnd();
            d = '{2'(i % 3), 6'(rnd())};
            base = p;
            strobe(load);
            bitWr = '{d, 1'b1};
            strobe(bitWrValid);
            strobe(scanDone);
            check(bit_now(), 1'b1);
            arm_slot(2'h0, 1'b1, exp_pos(sel, p) + 32'h3);
            arm_slot(2'h1, 1'b1, exp_pos(sel, p) + 32'h80000003);
            run = 1'b1;
            n = 0;
            while (matchPulse[0] !== 1'b1 && n < 20)
            begin
                @(posedge core_clk);
                #1 n++;
            end
            check(matchPulse, 4'h1);
            if (d.kind == pcr_pkg::DEST_SLOW)
            begin
                check(bit_now(), 1'b1);
                strobe(scanDone);
            end
            check(bit_now(), 1'b0);
            run = 1'b0;
            arm_slot(2'h0, 1'b0, 32'h0);
            check(matchPulse, 4'h0);
            arm_slot(2'h1, 1'b0, 32'h0);
        end
        for (int k = 0; k < 4; k++)
        begin
            // Unsupported codes on both sides of the legal ranges.
            sel = (k == 0) ? 8'h03 : (k == 1) ? 8'h0A : (k == 2) ? 8'h0E :
                  8'(32'h10 + rnd() % 32'hEF);
            arm_slot(2'h0, 1'b1, rnd());
            check(selError, 1'b1);
        end
        sel = pcr_pkg::SEL_X_PULSE;
        arm_slot(2'h0, 1'b1, exp_pos(sel, p) + 32'h80000000);
        sel = pcr_pkg::SEL_X_CAM;
        arm_slot(2'h1, 1'b1, exp_pos(sel, p) + 32'h80000000);
        @(posedge core_clk);
        #1 check(sourceConflict, 3'h1);
        arm_slot(2'h1, 1'b0, 32'h0);
        @(posedge core_clk);
        #1 check(sourceConflict, 3'h0);
        // The last relay was cleared by its match; a write while frozen must not land.
        clkEn = 1'b0;
        bitWr = '{d, 1'b1};
        strobe(bitWrValid);
        check(bit_now(), 1'b0);
        clkEn = 1'b1;
        strobe(bitWrValid);
        check(bit_now(), 1'b1);
        complete_run();
    end
endmodule // position_compare_reset_tb
